// ### rtl/dwt_pkg.sv
`default_nettype none

package dwt_pkg;

    // ************************************************************
    // Addressing, instruction fields and reset values
    // ************************************************************
    localparam logic [6:0] ADDR_FIXED      = 7'h2f;
    localparam logic [4:0] ADDR_PIN_PREFIX = 5'h0b;
    localparam int         RW_POS          = 0;
    localparam logic       RW_READ         = 1'b1;
    localparam int         INSTR_SEL_POS   = 7;
    localparam int         INSTR_SD_POS    = 6;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic [2:0] BIT_FIRST       = 3'h0;
    localparam logic [7:0] WIPER_MIDSCALE  = 8'h80;
    localparam logic [7:0] TAP_AT_B        = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_INSTR,
        ST_INSTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } dwt_state_e;

    typedef struct packed {
        logic       channel_select;
        logic       wiper_shutdown;
        logic [7:0] wiper_latch_1;
        logic [7:0] wiper_latch_2;
    } dwt_setting_s;

    typedef struct packed {
        logic use_pins;
        logic address_pin_high;
        logic address_pin_low;
    } dwt_strap_s;

    localparam dwt_setting_s SETTING_RESET = '{1'b0, 1'b0, WIPER_MIDSCALE, WIPER_MIDSCALE};
    localparam dwt_strap_s   STRAP_RESET   = '{1'b0, 1'b0, 1'b0};

endpackage

`default_nettype wire

// ### rtl/dwt_sync.sv
`timescale 1ns/100ps
`default_nettype none

module dwt_sync
    import dwt_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] dout_d;

    // A change counts only once the last two stages agree
    always_comb
    begin
        dout_d = dout_q;
        if (s2_q == s3_q)
        begin
            dout_d = s3_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            dout_q <= '0;
        end
        else
        begin
            s1_q   <= din;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            dout_q <= dout_d;
        end
    end

endmodule // dwt_sync

`default_nettype wire

// ### rtl/dwt_target.sv
// Contract
// - A start, data falling while clock high, begins a new address byte.
// - Address is seven fixed bits, or two low bits from address pins.
// - On address match the target pulls data low in the ninth pulse.
// - On mismatch the target idles and never drives data.
// - Direction bit high means read, low means write.
// - Instruction bit 7 picks the channel: low one, high two.
// - Shutdown bit opens A, wiper to B, stored value kept.
// - Latches load during shutdown; leaving it applies the stored value.
// - The six low instruction bits are ignored.
// - After the instruction ack a nine-clock data byte loads the latch.
// - Data changes only with clock low, except start and stop.
// - Read data follows the address ack directly, no instruction byte.
// - Read returns the channel last selected by a write instruction.
// - A write ending after the instruction still updates the selection.
// - A stop is not detected; the target leaves a write only on the next start.
// - Each further write data byte updates the selected wiper.
// - Repeated acknowledged reads keep returning the selected latch.
// - Both latches come up at midscale.
// - Each latch is eight bits selecting one tap position.
`timescale 1ns/100ps
`default_nettype none

module dwt_target
    import dwt_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic       SCL,
    input  wire logic       SDA_I,
    output var  logic       SDA_O,
    output var  logic       SDA_OE,
    input  wire logic       ADDR_FROM_PINS,
    input  wire logic       ADDRESS_PIN_HIGH,
    input  wire logic       ADDRESS_PIN_LOW,
    output var  logic [7:0] WIPER_LATCH_1,
    output var  logic [7:0] WIPER_LATCH_2,
    output var  logic [7:0] TAP_CODE_1,
    output var  logic [7:0] TAP_CODE_2,
    output var  logic       TERM_A_OPEN,
    output var  logic       CHANNEL_SELECT,
    output var  logic       WIPER_SHUTDOWN
);

    // ************************************************************
    // Link side: runs on the serial clock
    // ************************************************************
    logic         scl_n;
    logic         rst_link;
    dwt_strap_s   strap_raw;
    dwt_strap_s   strap;
    logic [6:0]   own_addr;
    logic         sda_pos_q;
    logic         start_cap_q;
    logic         start_used_q;
    logic         start_used_d;
    logic         start;
    dwt_state_e   st_q;
    dwt_state_e   st_d;
    logic [2:0]   cnt_q;
    logic [2:0]   cnt_d;
    logic [7:0]   rx_q;
    logic [7:0]   rx_d;
    logic [7:0]   rx_next;
    logic [7:0]   tx_q;
    logic [7:0]   tx_d;
    logic [7:0]   read_byte;
    logic         oe_q;
    logic         oe_d;
    logic         rw_q;
    logic         rw_d;
    dwt_setting_s set_q;
    dwt_setting_s set_d;
    logic         tgl_q;
    logic         tgl_d;

    // Falling edges drive the pin, rising edges sample it
    assign scl_n = ~SCL;

    dwt_sync #(.WIDTH(1)) u_rst_link (
        .clk    (scl_n),
        .rst    (1'b0),
        .din    (RST),
        .dout_q (rst_link)
    );

    assign strap_raw = '{ADDR_FROM_PINS, ADDRESS_PIN_HIGH, ADDRESS_PIN_LOW};

    dwt_sync #(.WIDTH(3)) u_strap (
        .clk    (scl_n),
        .rst    (rst_link),
        .din    (strap_raw),
        .dout_q (strap)
    );

    assign own_addr = strap.use_pins ? {ADDR_PIN_PREFIX, strap.address_pin_high, strap.address_pin_low}
                                     : ADDR_FIXED;

    // Data is taken while the clock is high and stable
    always_ff @(posedge SCL)
    begin
        sda_pos_q <= SDA_I;
    end

    // A data fall with the clock high marks a start; each data fall
    // with the clock low clears it, and every read byte acknowledged by the controller has one in its ack
    always_ff @(negedge SDA_I)
    begin
        if (rst_link)
        begin
            start_cap_q <= 1'b0;
        end
        else
        begin
            start_cap_q <= SCL;
        end
    end

    // Used once, so a stale capture cannot restart a frame twice
    assign start   = start_cap_q & ~start_used_q;
    assign rx_next = {rx_q[6:0], sda_pos_q};
    assign read_byte = set_q.channel_select ? set_q.wiper_latch_2 : set_q.wiper_latch_1;

    always_comb
    begin
        st_d         = st_q;
        cnt_d        = cnt_q;
        rx_d         = rx_q;
        tx_d         = tx_q;
        oe_d         = oe_q;
        rw_d         = rw_q;
        set_d        = set_q;
        tgl_d        = tgl_q;
        start_used_d = start_cap_q;
        if (start)
        begin
            st_d  = ST_ADDR;
            cnt_d = BIT_FIRST;
            oe_d  = 1'b0;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                begin
                    oe_d = 1'b0;
                end
                ST_ADDR:
                begin
                    rx_d  = rx_next;
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST)
                    begin
                        if (rx_next[7:1] == own_addr)
                        begin
                            st_d = ST_ADDR_ACK;
                            oe_d = 1'b1;
                            rw_d = rx_next[RW_POS];
                        end
                        else
                        begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    cnt_d = BIT_FIRST;
                    if (rw_q == RW_READ)
                    begin
                        st_d = ST_RDATA;
                        tx_d = read_byte;
                        oe_d = ~read_byte[7];
                    end
                    else
                    begin
                        st_d = ST_INSTR;
                        oe_d = 1'b0;
                    end
                end
                ST_INSTR:
                begin
                    rx_d  = rx_next;
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST)
                    begin
                        // Low six bits are simply not looked at
                        set_d.channel_select = rx_next[INSTR_SEL_POS];
                        set_d.wiper_shutdown = rx_next[INSTR_SD_POS];
                        tgl_d = ~tgl_q;
                        oe_d  = 1'b1;
                        st_d  = ST_INSTR_ACK;
                    end
                end
                ST_INSTR_ACK:
                begin
                    oe_d = 1'b0;
                    st_d = ST_WDATA;
                end
                ST_WDATA:
                begin
                    rx_d  = rx_next;
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST)
                    begin
                        if (set_q.channel_select)
                        begin
                            set_d.wiper_latch_2 = rx_next;
                        end
                        else
                        begin
                            set_d.wiper_latch_1 = rx_next;
                        end
                        tgl_d = ~tgl_q;
                        oe_d  = 1'b1;
                        st_d  = ST_WDATA_ACK;
                    end
                end
                ST_WDATA_ACK:
                begin
                    // Stays ready for more bytes; only a start ends it, a stop is not seen
                    oe_d = 1'b0;
                    st_d = ST_WDATA;
                end
                ST_RDATA:
                begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST)
                    begin
                        oe_d = 1'b0;
                        st_d = ST_RDATA_ACK;
                    end
                    else
                    begin
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_d = ~tx_q[6];
                    end
                end
                ST_RDATA_ACK:
                begin
                    if (!sda_pos_q)
                    begin
                        st_d  = ST_RDATA;
                        cnt_d = BIT_FIRST;
                        tx_d  = read_byte;
                        oe_d  = ~read_byte[7];
                    end
                    else
                    begin
                        st_d = ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge scl_n)
    begin
        if (rst_link)
        begin
            st_q         <= ST_IDLE;
            cnt_q        <= BIT_FIRST;
            rx_q         <= '0;
            tx_q         <= '0;
            oe_q         <= 1'b0;
            rw_q         <= 1'b0;
            set_q        <= SETTING_RESET;
            tgl_q        <= 1'b0;
            start_used_q <= 1'b0;
            SDA_O        <= 1'b0;
        end
        else
        begin
            st_q         <= st_d;
            cnt_q        <= cnt_d;
            rx_q         <= rx_d;
            tx_q         <= tx_d;
            oe_q         <= oe_d;
            rw_q         <= rw_d;
            set_q        <= set_d;
            tgl_q        <= tgl_d;
            start_used_q <= start_used_d;
            SDA_O        <= 1'b0;
        end
    end

    // Open drain: only ever pulls low
    assign SDA_OE = oe_q;

    // ************************************************************
    // Core side: mirrors the setting and drives the resistor
    // ************************************************************
    logic         tsync;
    logic         seen_q;
    logic         seen_d;
    dwt_setting_s mirror_q;
    dwt_setting_s mirror_d;
    logic [7:0]   tap1_q;
    logic [7:0]   tap1_d;
    logic [7:0]   tap2_q;
    logic [7:0]   tap2_d;

    dwt_sync #(.WIDTH(1)) u_tgl (
        .clk    (CORE_CLK),
        .rst    (RST),
        .din    (tgl_q),
        .dout_q (tsync)
    );

    // The setting is held for a whole byte after each toggle, so it is
    // long stable by the time the toggle has crossed
    always_comb
    begin
        seen_d   = tsync;
        mirror_d = mirror_q;
        if (tsync != seen_q)
        begin
            mirror_d = set_q;
        end
        // Shutdown parks the wiper at B but leaves both latches alone
        tap1_d = mirror_d.wiper_shutdown ? TAP_AT_B : mirror_d.wiper_latch_1;
        tap2_d = mirror_d.wiper_shutdown ? TAP_AT_B : mirror_d.wiper_latch_2;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            seen_q   <= 1'b0;
            mirror_q <= SETTING_RESET;
            tap1_q   <= WIPER_MIDSCALE;
            tap2_q   <= WIPER_MIDSCALE;
        end
        else
        begin
            seen_q   <= seen_d;
            mirror_q <= mirror_d;
            tap1_q   <= tap1_d;
            tap2_q   <= tap2_d;
        end
    end

    assign WIPER_LATCH_1  = mirror_q.wiper_latch_1;
    assign WIPER_LATCH_2  = mirror_q.wiper_latch_2;
    assign TAP_CODE_1     = tap1_q;
    assign TAP_CODE_2     = tap2_q;
    assign TERM_A_OPEN    = mirror_q.wiper_shutdown;
    assign CHANNEL_SELECT = mirror_q.channel_select;
    assign WIPER_SHUTDOWN = mirror_q.wiper_shutdown;

    // ************************************************************
    // Checks
    // ************************************************************
    a_start_rearm: assert property (@(posedge scl_n) disable iff (rst_link)
        start |=> (st_q == ST_ADDR) && (cnt_q == BIT_FIRST) && !oe_q)
        else $error("start did not rearm the address byte");

    a_addr_ack: assert property (@(posedge scl_n) disable iff (rst_link)
        (!start && st_q == ST_ADDR && cnt_q == BIT_LAST && rx_next[7:1] == own_addr)
        |=> (st_q == ST_ADDR_ACK) && oe_q ##1 (oe_q == ((rw_q == RW_READ) && !$past(read_byte[7]))))
        else $error("matching address not acknowledged for one slot");

    a_addr_miss: assert property (@(posedge scl_n) disable iff (rst_link)
        (!start && st_q == ST_ADDR && cnt_q == BIT_LAST && rx_next[7:1] != own_addr)
        |=> (st_q == ST_IDLE) && !oe_q)
        else $error("foreign address not ignored");

    a_read_first: assert property (@(posedge scl_n) disable iff (rst_link)
        (!start && st_q == ST_ADDR_ACK && rw_q)
        |=> (st_q == ST_RDATA) && (oe_q == !$past(read_byte[7])))
        else $error("read data does not follow address ack");

    a_read_order: assert property (@(posedge scl_n) disable iff (rst_link)
        (!start && st_q == ST_RDATA && cnt_q != BIT_LAST) |=> (oe_q == !$past(tx_q[6])))
        else $error("read bit order wrong");

    a_instr_sel: assert property (@(posedge scl_n) disable iff (rst_link)
        (!start && st_q == ST_INSTR && cnt_q == BIT_LAST)
        |=> (set_q.channel_select == $past(rx_q[6])) && (set_q.wiper_shutdown == $past(rx_q[5])))
        else $error("instruction fields not taken");

    a_data_load: assert property (@(posedge scl_n) disable iff (rst_link)
        (!start && st_q == ST_WDATA && cnt_q == BIT_LAST && !set_q.channel_select)
        |=> (set_q.wiper_latch_1 == {$past(rx_q[6:0]), $past(sda_pos_q)}))
        else $error("data byte not loaded into latch one");

    a_nack_idle: assert property (@(posedge scl_n) disable iff (rst_link)
        (!start && st_q == ST_RDATA_ACK && sda_pos_q) |=> (st_q == ST_IDLE) && !oe_q)
        else $error("read did not end on not-acknowledge");

    a_repeat_write: assert property (@(posedge scl_n) disable iff (rst_link)
        (!start && st_q == ST_WDATA_ACK) |=> (st_q == ST_WDATA) && !oe_q)
        else $error("write did not accept a further byte");

    a_mirror_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
        (tsync != seen_q) |=> (mirror_q == $past(set_q)))
        else $error("core did not take the new setting");

    a_tap_shutdown: assert property (@(posedge CORE_CLK) disable iff (RST)
        mirror_q.wiper_shutdown |-> (tap1_q == TAP_AT_B) && (tap2_q == TAP_AT_B) && TERM_A_OPEN)
        else $error("shutdown does not park the wiper at B");

    a_resume_latch: assert property (@(posedge CORE_CLK) disable iff (RST)
        $fell(mirror_q.wiper_shutdown) |-> (tap1_q == mirror_q.wiper_latch_1)
                                          && (tap2_q == mirror_q.wiper_latch_2))
        else $error("stored value not applied after shutdown");

    a_reset_mid: assert property (@(posedge CORE_CLK) disable iff (RST)
        $fell(RST) |-> (mirror_q.wiper_latch_1 == WIPER_MIDSCALE) && (tap2_q == WIPER_MIDSCALE))
        else $error("latches not at midscale after reset");

    c_read_repeat: cover property (@(posedge scl_n) disable iff (rst_link)
        st_q == ST_RDATA_ACK && !sda_pos_q && !start);
    c_write_two: cover property (@(posedge scl_n) disable iff (rst_link)
        st_q == ST_WDATA_ACK ##9 st_q == ST_WDATA_ACK);
    c_addr_miss: cover property (@(posedge scl_n) disable iff (rst_link)
        st_q == ST_ADDR && cnt_q == BIT_LAST && rx_next[7:1] != own_addr);
    c_shutdown: cover property (@(posedge CORE_CLK) disable iff (RST)
        $fell(mirror_q.wiper_shutdown));

endmodule // dwt_target

`default_nettype wire

// ### test/dwt_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none

module dwt_ctl_model
(
    output var  logic scl,
    output var  logic pull_low,
    input  wire logic sda
);
    // ********************
    // Bus controller, 48 ns serial period
    // ********************
    initial
    begin
        scl      = 1'b1;
        pull_low = 1'b0;
    end

    // Data moves only in the low half of the clock
    task automatic clk_bit(input logic b, output logic rb);
    begin
        #6 pull_low = ~b;
        #18 scl = 1'b1;
        #12 rb = sda;
        #12 scl = 1'b0;
    end
    endtask

    // Also serves as repeated start
    task automatic start();
    begin
        #6 pull_low = 1'b0;
        #18 scl = 1'b1;
        #12 pull_low = 1'b1;
        #12 scl = 1'b0;
    end
    endtask

    // Line is left high and clock stands still until the next frame
    task automatic stop();
    begin
        #6 pull_low = 1'b1;
        #18 scl = 1'b1;
        #12 pull_low = 1'b0;
        #12;
    end
    endtask

    // Link logic only moves on clock edges, so reset and strap changes need a few pulses
    task automatic idle_clocks(input int n);
    begin
        repeat (n)
        begin
            #24 scl = 1'b0;
            #8 pull_low = 1'b1;
            #8 pull_low = 1'b0;
            #8 scl = 1'b1;
        end
    end
    endtask

    task automatic write_byte(input logic [7:0] v, output logic ack);
        logic rb;
    begin
        for (int i = 7; i >= 0; i--)
            clk_bit(v[i], rb);
        clk_bit(1'b1, rb);
        ack = ~rb;
    end
    endtask

    task automatic read_byte(input logic more, output logic [7:0] v);
        logic rb;
    begin
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, v[i]);
        clk_bit(~more, rb);
    end
    endtask
endmodule // dwt_ctl_model

`default_nettype wire

// ### test/dual_wiper_two_wire_target_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dual_wiper_two_wire_target_tb
    import dwt_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst, pins, pin_h, pin_l, scl, pull_low, oe, o, a_open, sel, shut, ack;
    logic [7:0] lat1, lat2, tap1, tap2, v;
    logic [7:0] exp_lat [2];
    logic       exp_sel, exp_shut;
    wire        sda;
    int         err_count = 0;
    int         check_count = 0;
    integer     seed = 32'he583c8d9;

    always #20 clk = ~clk;

    // Open drain: any party pulling low wins over the pull-up
    assign sda = (oe ? o : 1'b1) & ~pull_low;

    dwt_ctl_model u_ctl (.scl(scl), .pull_low(pull_low), .sda(sda));

    dwt_target u_dut (
        .CORE_CLK(clk), .RST(rst), .SCL(scl), .SDA_I(sda), .SDA_O(o), .SDA_OE(oe),
        .ADDR_FROM_PINS(pins), .ADDRESS_PIN_HIGH(pin_h), .ADDRESS_PIN_LOW(pin_l),
        .WIPER_LATCH_1(lat1), .WIPER_LATCH_2(lat2), .TAP_CODE_1(tap1), .TAP_CODE_2(tap2),
        .TERM_A_OPEN(a_open), .CHANNEL_SELECT(sel), .WIPER_SHUTDOWN(shut)
    );

    // ********************
    // Compare and report
    // ********************
    task automatic chk_val(input string name, input logic [7:0] e, input logic [7:0] g);
    begin
        check_count++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", name, e, g);
            err_count++;
        end
    end
    endtask

    task automatic chk_bit(input string name, input logic e, input logic g);
    begin
        check_count++;
        if (g !== e)
        begin
            $display("ERROR %s expected %b seen %b", name, e, g);
            err_count++;
        end
    end
    endtask

    task automatic finish_test();
    begin
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // ********************
    // Transfers and expectations
    // ********************
    function automatic logic [6:0] own_addr();
        return pins ? {ADDR_PIN_PREFIX, pin_h, pin_l} : ADDR_FIXED;
    endfunction

    task automatic check_outputs();
    begin
        chk_val("latch 1", exp_lat[0], lat1);
        chk_val("latch 2", exp_lat[1], lat2);
        chk_val("tap 1", exp_shut ? TAP_AT_B : exp_lat[0], tap1);
        chk_val("tap 2", exp_shut ? TAP_AT_B : exp_lat[1], tap2);
        chk_bit("a open", exp_shut, a_open);
        chk_bit("select", exp_sel, sel);
        chk_bit("shutdown", exp_shut, shut);
    end
    endtask

    task automatic do_write(input logic [7:0] instr, input int n, input logic [15:0] dat);
    begin
        u_ctl.start();
        u_ctl.write_byte({own_addr(), 1'b0}, ack);
        chk_bit("address ack", 1'b1, ack);
        u_ctl.write_byte(instr, ack);
        chk_bit("instruction ack", 1'b1, ack);
        exp_sel = instr[INSTR_SEL_POS];
        exp_shut = instr[INSTR_SD_POS];
        for (int k = 0; k < n; k++)
        begin
            u_ctl.write_byte(dat[15-8*k -: 8], ack);
            chk_bit("data ack", 1'b1, ack);
            exp_lat[exp_sel] = dat[15-8*k -: 8];
        end
        u_ctl.stop();
        repeat (10) @(posedge clk);
        #2 check_outputs();
    end
    endtask

    task automatic do_read(input int n);
    begin
        u_ctl.start();
        u_ctl.write_byte({own_addr(), 1'b1}, ack);
        chk_bit("read address ack", 1'b1, ack);
        for (int k = 0; k < n; k++)
        begin
            u_ctl.read_byte(k < n - 1, v);
            chk_val("read data", exp_lat[exp_sel], v);
        end
        u_ctl.stop();
    end
    endtask

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        rst = 1'b1;
        pins = 1'b0;
        pin_h = 1'b0;
        pin_l = 1'b0;
        exp_lat = '{8'h80, 8'h80};
        exp_sel = 1'b0;
        exp_shut = 1'b0;
        repeat (2) @(posedge clk);
        u_ctl.idle_clocks(8);
        @(posedge clk);
        #2 rst = 1'b0;
        u_ctl.idle_clocks(5);
        check_outputs();
        $display("reset values done");
        do_write(8'hc0, 1, 16'h5a00);
        do_write(8'h80, 0, 16'h0000);
        do_read(1);
        do_write(8'h3f, 0, 16'h0000);
        do_read(3);
        $display("shutdown and select done");
        u_ctl.start();
        u_ctl.write_byte({own_addr() ^ 7'h01, 1'b0}, ack);
        chk_bit("foreign address ack", 1'b0, ack);
        u_ctl.write_byte(8'h80, ack);
        chk_bit("foreign instruction ack", 1'b0, ack);
        u_ctl.stop();
        repeat (10) @(posedge clk);
        #2 check_outputs();
        $display("foreign address done");
        for (int i = 0; i < 30; i++)
        begin
            @(posedge clk);
            #2 {pins, pin_h, pin_l} = 3'($random(seed));
            u_ctl.idle_clocks(5);
            do_write(8'($random(seed)), {$random(seed)} % 3, 16'($random(seed)));
            do_read(1 + {$random(seed)} % 3);
        end
        $display("random transfers done");
        finish_test();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        $display("ERROR watchdog expected finish seen timeout");
        finish_test();
    end
endmodule // dual_wiper_two_wire_target_tb

`default_nettype wire
